//--- logic/igp_pkg.sv
// constants and carrier types for the inverter gate protection block
package igp_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned FAULT_TIME_NS   = 40000;
  localparam int unsigned FAULT_CNT_W     = 12;
  localparam int unsigned FAULT_CYC_INT   = (FAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CYC = FAULT_CNT_W'(FAULT_CYC_INT);
  localparam int unsigned SYNC_STAGES     = 2;

  // reset values: every switch starts locked off; a command held high through reset unlocks it with no fresh edge
  localparam logic [2:0] LOCK_RST         = 3'h7;
  localparam logic [2:0] GATE_OFF         = 3'h0;

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } igp_gate_s;

  typedef struct packed {
    logic       sc_trip;
    logic       low_uv;
    logic [2:0] high_uv;
    logic       temp_over_trip;
    logic       temp_below_release;
    logic       temp_sense_loaded;
  } igp_sense_s;

  localparam int unsigned GATE_W  = $bits(igp_gate_s);
  localparam int unsigned SENSE_W = $bits(igp_sense_s);

endpackage

//--- logic/igp_protect.sv
// gate command gating and fault signalling for a three-phase inverter
// Notes on behaviour
// - A low-side short circuit forces all three low-side drives off at once; high sides stay.
// - A short-circuit trip gives one fault pulse of at least 40 us.
// - While the fault output is active blocked switches stay off, and a held command stays off.
// - Low-side supply undervoltage turns all low-side switches off whatever the commands.
// - Low-side undervoltage holds the fault output for its whole length and at least 40 us.
// - After low-side undervoltage ends, low-side switches restart only on a new command edge.
// - High-side undervoltage of a phase turns that high switch off without a fault output.
// - After high-side supply recovery that switch restarts only on its next command edge.
// - Over temperature turns all low-side switches off whatever the commands.
// - Over temperature holds the fault output for its whole length and at least 40 us.
// - Over temperature clears at the release level and low sides restart on the next edge.
// - A loaded temperature output disables the internal over temperature shutdown.
// - A high gate command means on and a low one means off.
// - Over temperature releases only at the lower release level or on a loaded temperature output, giving hysteresis.
`timescale 1ns/100ps
module igp_protect
  import igp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              phase_u_high_cmd,
  input  wire logic              phase_v_high_cmd,
  input  wire logic              phase_w_high_cmd,
  input  wire logic              phase_u_low_cmd,
  input  wire logic              phase_v_low_cmd,
  input  wire logic              phase_w_low_cmd,
  input  wire igp_pkg::igp_sense_s sense,
  output igp_pkg::igp_gate_s     gate_drv,
  output logic                   fault_out_n,
  output logic                   fault_out_oe
);

  import igp_pkg::*;

  typedef struct packed {
    igp_gate_s              cmd_prev;
    igp_gate_s              lock;
    igp_gate_s              drv;
    logic [FAULT_CNT_W-1:0] cnt;
    logic                   ot;
    logic                   sc_prev;
    logic                   uv_prev;
    logic                   fault;
  } igp_state_s;

  igp_state_s q;
  igp_state_s d;
  igp_gate_s  cmd_raw;
  igp_gate_s  cmd_s;
  igp_sense_s sns;
  igp_gate_s  rise;
  logic       start;
  logic       lo_blk;

  assign cmd_raw.hi = {phase_w_high_cmd, phase_v_high_cmd, phase_u_high_cmd};
  assign cmd_raw.lo = {phase_w_low_cmd, phase_v_low_cmd, phase_u_low_cmd};

  // pins come from the controller and analog comparators, not this clock
  igp_sync #(
    .W (GATE_W + SENSE_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({cmd_raw, sense}),
    .dout    ({cmd_s, sns})
  );

  always_comb
  begin
    d = q;
    rise = igp_gate_s'(cmd_s & ~q.cmd_prev);
    // hysteresis: trip and release come from two comparators
    if (sns.temp_sense_loaded)
    begin
      d.ot = 1'b0;
    end
    else if (sns.temp_over_trip)
    begin
      d.ot = 1'b1;
    end
    else if (sns.temp_below_release)
    begin
      d.ot = 1'b0;
    end
    start = (sns.sc_trip & ~q.sc_prev) | (sns.low_uv & ~q.uv_prev) | (d.ot & ~q.ot);
    d.sc_prev = sns.sc_trip;
    d.uv_prev = sns.low_uv;
    // a new event restarts the full pulse rather than extending a partial one
    if (start)
    begin
      d.cnt = FAULT_CYC;
    end
    else if (q.cnt != '0)
    begin
      d.cnt = FAULT_CNT_W'(q.cnt - 1'b1);
    end
    d.fault = sns.low_uv | d.ot | (d.cnt != '0);
    lo_blk = sns.sc_trip | d.fault;
    if (lo_blk)
    begin
      d.lock.lo = LOCK_RST;
    end
    else
    begin
      d.lock.lo = q.lock.lo & ~rise.lo;
    end
    // high side never raises the fault output
    d.lock.hi = (q.lock.hi & ~rise.hi) | sns.high_uv;
    d.drv = igp_gate_s'(cmd_s & ~d.lock);
    d.cmd_prev = cmd_s;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.cmd_prev <= '0;
      q.lock     <= '{hi: LOCK_RST, lo: LOCK_RST};
      q.drv      <= '{hi: GATE_OFF, lo: GATE_OFF};
      q.cnt      <= '0;
      q.ot       <= 1'b0;
      q.sc_prev  <= 1'b0;
      q.uv_prev  <= 1'b0;
      q.fault    <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign gate_drv     = q.drv;
  assign fault_out_n  = ~q.fault;
  assign fault_out_oe = q.fault;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_sc_edge;
    sns.sc_trip && !q.sc_prev;
  endsequence

  sequence s_fault_release;
    q.fault ##1 !q.fault;
  endsequence

  sequence s_lo_rise0;
    !q.drv.lo[0] ##1 q.drv.lo[0];
  endsequence

  sequence s_pulse_last;
    (q.cnt == FAULT_CNT_W'(1)) && !start;
  endsequence

  AST_SC_LOW_OFF: assert property (
    sns.sc_trip |=> (gate_drv.lo == GATE_OFF))
    else $error("low side driven during short circuit");

  AST_SC_HIGH_KEEP: assert property (
    sns.sc_trip && (sns.high_uv == 3'h0) && (q.lock.hi == 3'h0)
      |=> (gate_drv.hi == $past(cmd_s.hi)))
    else $error("high side disturbed by short circuit");

  AST_SC_PULSE_LOAD: assert property (
    s_sc_edge |=> (q.cnt == FAULT_CYC) ##0 !fault_out_n)
    else $error("short circuit pulse not started at full length");

  AST_PULSE_COUNT: assert property (
    (q.cnt != '0) && !start
      |=> (q.cnt == FAULT_CNT_W'($past(q.cnt) - 1'b1)) && ((q.cnt == '0) || !fault_out_n))
    else $error("fault pulse counter not stepping");

  AST_FAULT_BLOCKS_LOW: assert property (
    !fault_out_n |-> (gate_drv.lo == GATE_OFF))
    else $error("low side on while fault output active");

  AST_RELEASE_LOCKED: assert property (
    s_fault_release |-> ($past(rise.lo) != 3'h0) || (q.lock.lo == LOCK_RST))
    else $error("low side not locked at end of fault");

  AST_UV_LOW_OFF: assert property (
    sns.low_uv |=> (gate_drv.lo == GATE_OFF) && !fault_out_n)
    else $error("low undervoltage not blocking with fault");

  AST_UV_MIN_PULSE: assert property (
    sns.low_uv && !q.uv_prev |=> (q.cnt == FAULT_CYC))
    else $error("undervoltage pulse not at full length");

  AST_LOW_EDGE_ONLY: assert property (
    s_lo_rise0 |-> $past(cmd_s.lo[0]) && !$past(q.cmd_prev.lo[0]))
    else $error("low side turned on without command edge");

  AST_HUV_OFF: assert property (
    sns.high_uv[1] |=> !gate_drv.hi[1])
    else $error("high side on during its undervoltage");

  AST_HUV_NO_FAULT: assert property (
    (sns.high_uv != 3'h0) && (q.cnt == '0) && !start && !sns.low_uv && !d.ot
      |=> fault_out_n)
    else $error("fault raised for high side undervoltage");

  AST_HIGH_EDGE_ONLY: assert property (
    $rose(q.drv.hi[2]) |-> $past(cmd_s.hi[2]) && !$past(q.cmd_prev.hi[2]))
    else $error("high side turned on without command edge");

  AST_OT_OFF: assert property (
    q.ot |-> (gate_drv.lo == GATE_OFF) && !fault_out_n)
    else $error("over temperature not blocking with fault");

  AST_OT_LOADED: assert property (
    sns.temp_sense_loaded |=> !q.ot)
    else $error("over temperature active with loaded sense output");

  AST_OT_HYST: assert property (
    q.ot && !sns.temp_below_release && !sns.temp_sense_loaded |=> q.ot)
    else $error("over temperature released above release level");

  AST_ON_MEANS_HIGH: assert property (
    (gate_drv & ~$past(cmd_s)) == '0)
    else $error("switch on without high command");

  AST_PIN_OE: assert property (
    fault_out_oe == !fault_out_n)
    else $error("fault pin enable disagrees with level");

  AST_SC_LOCK_LOW: assert property (
    sns.sc_trip |=> (q.lock.lo == LOCK_RST))
    else $error("low side not locked during short circuit");

  AST_PULSE_END: assert property (
    s_pulse_last ##0 (!sns.low_uv && !d.ot) |=> fault_out_n)
    else $error("fault output held past the fixed pulse");

  AST_CNT_RANGE: assert property (
    q.cnt <= FAULT_CYC)
    else $error("fault pulse counter above full length");

  AST_FAULT_HIGH_FREE: assert property (
    !fault_out_n && (sns.high_uv == 3'h0) && (q.lock.hi == 3'h0)
      |=> (gate_drv.hi == $past(cmd_s.hi)))
    else $error("high side disturbed by fault output");

  AST_UV_LOCK_LOW: assert property (
    sns.low_uv |=> (q.lock.lo == LOCK_RST))
    else $error("low side not locked during undervoltage");

  AST_LOW_EDGE_ONLY1: assert property (
    $rose(q.drv.lo[1]) |-> $past(cmd_s.lo[1]) && !$past(q.cmd_prev.lo[1]))
    else $error("low side v turned on without command edge");

  AST_LOW_EDGE_ONLY2: assert property (
    $rose(q.drv.lo[2]) |-> $past(cmd_s.lo[2]) && !$past(q.cmd_prev.lo[2]))
    else $error("low side w turned on without command edge");

  AST_HUV_OFF0: assert property (
    sns.high_uv[0] |=> !gate_drv.hi[0])
    else $error("high side u on during its undervoltage");

  AST_HUV_OFF2: assert property (
    sns.high_uv[2] |=> !gate_drv.hi[2])
    else $error("high side w on during its undervoltage");

  AST_FAULT_SOURCE: assert property (
    !fault_out_n |-> q.ot || (q.cnt != '0) || $past(sns.low_uv))
    else $error("fault output without a low side cause");

  AST_HUV_LOCK: assert property (
    sns.high_uv[1] |=> q.lock.hi[1])
    else $error("high side not locked after its undervoltage");

  AST_HIGH_EDGE_ONLY0: assert property (
    $rose(q.drv.hi[0]) |-> $past(cmd_s.hi[0]) && !$past(q.cmd_prev.hi[0]))
    else $error("high side u turned on without command edge");

  AST_HIGH_EDGE_ONLY1: assert property (
    $rose(q.drv.hi[1]) |-> $past(cmd_s.hi[1]) && !$past(q.cmd_prev.hi[1]))
    else $error("high side v turned on without command edge");

  AST_OT_SET: assert property (
    sns.temp_over_trip && !sns.temp_sense_loaded |=> q.ot)
    else $error("over temperature not taken");

  AST_OT_PULSE_LOAD: assert property (
    $rose(q.ot) |-> (q.cnt == FAULT_CYC))
    else $error("over temperature pulse not started at full length");

  AST_OT_CLEAR: assert property (
    sns.temp_below_release && !sns.temp_over_trip |=> !q.ot)
    else $error("over temperature kept below release level");

endmodule

//--- logic/igp_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module igp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } igp_sync_s;

  igp_sync_s sync_q;
  igp_sync_s sync_d;

  // the meta stage feeds the sync stage only
  always_comb
  begin
    sync_d.meta = din;
    sync_d.sync = sync_q.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= '0;
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q.sync;

endmodule

//--- verification/igp_pwm_model.sv
// pwm controller model driving the six gate commands
`timescale 1ns/100ps
module igp_pwm_model
  import igp_pkg::*;
(
  input  wire logic         ref_clk,
  input  igp_pkg::igp_gate_s want,
  output igp_pkg::igp_gate_s cmd
);
  initial cmd = '0;
  // high requests on, low requests off; moves just after the edge
  // want is taken at the edge itself, so a bench change one step later cannot race it
  always @(posedge ref_clk)
  begin
    cmd <= #1 want;
  end
endmodule

//--- verification/testbench.sv
// self-checking testbench for the gate protection block
`timescale 1ns/100ps
module testbench;
  import igp_pkg::*;
  logic       ref_clk    = 1'b0;
  logic       rst_n      = 1'b0;
  igp_gate_s  want       = '0;
  igp_gate_s  cmd;
  igp_sense_s sense      = '0;
  igp_gate_s  gate_drv;
  logic       fault_out_n;
  logic       fault_out_oe;
  int         n_mismatch = 0;
  int         n_checks   = 0;

  always #5 ref_clk = ~ref_clk;

  igp_pwm_model u_pwm (.ref_clk(ref_clk), .want(want), .cmd(cmd));
  igp_protect DUT (.ref_clk(ref_clk), .rst_n(rst_n), .phase_u_high_cmd(cmd.hi[0]),
    .phase_v_high_cmd(cmd.hi[1]), .phase_w_high_cmd(cmd.hi[2]),
    .phase_u_low_cmd(cmd.lo[0]), .phase_v_low_cmd(cmd.lo[1]),
    .phase_w_low_cmd(cmd.lo[2]), .sense(sense), .gate_drv(gate_drv),
    .fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe));

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // commands dropped then raised so each unlocked switch sees a fresh edge
  task automatic arm;
    want = '0;
    wt(6);
    want = 6'h3f;
    wt(6);
  endtask

  task automatic t_gate;
    arm();
    chk("gate", gate_drv, 8'h3f);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    want = '0;
    wt(6);
    chk("gate", gate_drv, 8'h00);
    $display("gate test done");
  endtask

  // short trip pulse: the fault pulse must still last the full time
  task automatic t_sc;
    arm();
    sense.sc_trip = 1'b1;
    wt(4);
    chk("gate", gate_drv, 8'h38);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h1);
    wt(20);
    sense.sc_trip = 1'b0;
    wt(3900);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h1);
    chk("gate", gate_drv, 8'h38);
    wt(200);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    chk("gate", gate_drv, 8'h38);
    arm();
    chk("gate", gate_drv, 8'h3f);
    $display("short circuit test done");
  endtask

  task automatic t_luv;
    arm();
    // a short dip must still give the full minimum pulse
    sense.low_uv = 1'b1;
    wt(4);
    sense.low_uv = 1'b0;
    wt(3000);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h1);
    wt(1100);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    sense.low_uv = 1'b1;
    wt(4);
    chk("gate", gate_drv, 8'h38);
    wt(6000);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h1);
    sense.low_uv = 1'b0;
    wt(10);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    chk("gate", gate_drv, 8'h38);
    arm();
    chk("gate", gate_drv, 8'h3f);
    $display("low supply test done");
  endtask

  task automatic t_huv;
    arm();
    sense.high_uv = 3'h2;
    wt(4);
    chk("gate", gate_drv, 8'h2f);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    sense.high_uv = 3'h0;
    wt(6);
    chk("gate", gate_drv, 8'h2f);
    arm();
    chk("gate", gate_drv, 8'h3f);
    $display("high supply test done");
  endtask

  // trip input drops first: the state must hold until the release input
  task automatic t_ot;
    arm();
    sense.temp_over_trip = 1'b1;
    wt(4);
    chk("gate", gate_drv, 8'h38);
    sense.temp_over_trip = 1'b0;
    wt(5000);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h1);
    sense.temp_below_release = 1'b1;
    wt(10);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    chk("gate", gate_drv, 8'h38);
    sense.temp_below_release = 1'b0;
    arm();
    chk("gate", gate_drv, 8'h3f);
    sense.temp_sense_loaded = 1'b1;
    wt(4);
    sense.temp_over_trip = 1'b1;
    wt(10);
    chk("gate", gate_drv, 8'h3f);
    chk("fault", {fault_out_n, fault_out_oe}, 8'h2);
    sense = '0;
    $display("temperature test done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // tests take about 19400 cycles; the limit leaves a wide margin
  initial
  begin
    #1000000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    wt(3);
    t_gate();
    t_sc();
    t_luv();
    t_huv();
    t_ot();
    stop_test();
  end
endmodule
